// file: ifc_defs.svh
// register map, field positions, key values and reset values of the flash controller
`ifndef IFC_DEFS_SVH
`define IFC_DEFS_SVH
`define IFC_ADDR_PCR 8'hbf
`define IFC_ADDR_KEY 8'hc3
`define IFC_ADDR_AHI 8'hc4
`define IFC_ADDR_ALO 8'hc5
`define IFC_ADDR_FDATA 8'hc6
`define IFC_ADDR_CMD 8'hc7
`define IFC_KEY_FIRST 8'h87
`define IFC_KEY_SECOND 8'h59
`define IFC_PCR_WMASK 8'h9b
`define IFC_PCR_SWRESET 8'h83
`define IFC_PCR_RESET 8'h00
`define IFC_CMD_WMASK 8'h7f
`define IFC_CMD_RESET 8'h30
`define IFC_BYTE_RESET 8'h00
`define IFC_PCR_ISP 0
`define IFC_PCR_LOADER 5
`define IFC_CMD_BANK 6
`define IFC_CMD_OE 5
`define IFC_CMD_CE 4
`define IFC_CMD_CTRL_HI 3
`define IFC_OP_READ 4'h0
`endif

// file: ifc_pkg.sv
// types of the flash controller
package ifc_pkg;
  typedef enum logic [1:0] {key_locked, key_first, key_open} ifc_key_e;
  typedef enum logic [1:0] {op_run, op_busy, op_hold} ifc_op_e;
endpackage : ifc_pkg

// file: ifc_flash_ctrl.sv
// in-system programming flash controller
`timescale 1ns/1ps
`include "ifc_defs.svh"
module ifc_flash_ctrl import ifc_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic core_idle_in,
  output logic cpu_reset_out,
  output logic pc_clear_out,
  output logic fetch_loader_out,
  output logic flash_bank_out,
  output logic flash_output_enable_out,
  output logic flash_chip_enable_out,
  output logic [3:0] flash_ctrl_out,
  output logic [15:0] flash_addr_out,
  output logic [7:0] flash_wdata_out,
  output logic flash_start_out,
  input wire logic [7:0] flash_rdata_in,
  input wire logic flash_done_in
);
  ////////////////////////////////////////////////////////////////////////////
  ifc_key_e key_st, next_key_st;
  ifc_op_e op_st, next_op_st;
  logic [7:0] pcr, next_pcr;
  logic [7:0] cmd, next_cmd;
  logic [7:0] addr_hi, next_addr_hi;
  logic [7:0] addr_lo, next_addr_lo;
  logic [7:0] fdata, next_fdata;
  logic [7:0] rdata, next_rdata;
  logic loader, next_loader;
  logic idle_q, next_idle_q;
  logic start, next_start;
  logic rst_p, next_rst_p;
  logic pcc, next_pcc;
  logic wr_key, wr_pcr, wake, enter, is_read;

  assign wr_key = reg_wr_in && (reg_addr_in == `IFC_ADDR_KEY);
  assign wr_pcr = reg_wr_in && (reg_addr_in == `IFC_ADDR_PCR);
  assign wake = idle_q && !core_idle_in;
  assign enter = core_idle_in && !idle_q;
  assign is_read = cmd[`IFC_CMD_CTRL_HI:0] == `IFC_OP_READ;

  ////////////////////////////////////////////////////////////////////////////
  // unlock key sequence
  always_comb begin
    next_key_st = key_st;
    if (wr_key) begin
      if (reg_wdata_in == `IFC_KEY_FIRST) begin
        next_key_st = key_first;
      end else if (reg_wdata_in == `IFC_KEY_SECOND && key_st == key_first) begin
        next_key_st = key_open;
      end else begin
        next_key_st = key_locked;
      end
    end
    if (rst_p) begin
      next_key_st = key_locked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, read port and bank switching
  always_comb begin
    next_pcr = pcr;
    next_cmd = cmd;
    next_addr_hi = addr_hi;
    next_addr_lo = addr_lo;
    next_fdata = fdata;
    next_loader = loader;
    next_idle_q = core_idle_in;
    next_rst_p = 1'b0;
    next_pcc = 1'b0;
    next_rdata = 8'h00;
    if (wr_pcr && key_st == key_open) begin
      next_pcr = reg_wdata_in & `IFC_PCR_WMASK;
    end
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        `IFC_ADDR_CMD: next_cmd = reg_wdata_in & `IFC_CMD_WMASK;
        `IFC_ADDR_AHI: next_addr_hi = reg_wdata_in;
        `IFC_ADDR_ALO: next_addr_lo = reg_wdata_in;
        `IFC_ADDR_FDATA: next_fdata = reg_wdata_in;
        default: ;
      endcase
    end
    if (op_st == op_busy && flash_done_in && is_read) begin
      next_fdata = flash_rdata_in;
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `IFC_ADDR_PCR: begin
          next_rdata = pcr;
          next_rdata[`IFC_PCR_LOADER] = loader;
        end
        `IFC_ADDR_KEY: next_rdata = 8'h00;
        `IFC_ADDR_CMD: next_rdata = cmd;
        `IFC_ADDR_AHI: next_rdata = addr_hi;
        `IFC_ADDR_ALO: next_rdata = addr_lo;
        `IFC_ADDR_FDATA: next_rdata = fdata;
        default: next_rdata = 8'h00;
      endcase
    end
    if (wake) begin
      if ((pcr & `IFC_PCR_SWRESET) == `IFC_PCR_SWRESET) begin
        next_rst_p = 1'b1;
        next_loader = 1'b0;
        next_pcr = `IFC_PCR_RESET;
        next_cmd = `IFC_CMD_RESET;
      end else if (pcr[`IFC_PCR_ISP] && !loader) begin
        next_loader = 1'b1;
        next_pcc = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash operation sequencing
  always_comb begin
    next_op_st = op_st;
    next_start = 1'b0;
    unique case (op_st)
      op_run: begin
        if (enter && pcr[`IFC_PCR_ISP]) begin
          next_op_st = op_busy;
          next_start = 1'b1;
        end
      end
      op_busy: begin
        if (flash_done_in) begin
          next_op_st = op_hold;
        end else if (!core_idle_in) begin
          next_op_st = op_run;
        end
      end
      op_hold: begin
        if (!core_idle_in) begin
          next_op_st = op_run;
        end
      end
      default: next_op_st = op_run;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      key_st <= key_locked;
      op_st <= op_run;
      pcr <= `IFC_PCR_RESET;
      cmd <= `IFC_CMD_RESET;
      addr_hi <= `IFC_BYTE_RESET;
      addr_lo <= `IFC_BYTE_RESET;
      fdata <= `IFC_BYTE_RESET;
      rdata <= `IFC_BYTE_RESET;
      loader <= 1'b0;
      idle_q <= 1'b0;
      start <= 1'b0;
      rst_p <= 1'b0;
      pcc <= 1'b0;
    end else begin
      key_st <= next_key_st;
      op_st <= next_op_st;
      pcr <= next_pcr;
      cmd <= next_cmd;
      addr_hi <= next_addr_hi;
      addr_lo <= next_addr_lo;
      fdata <= next_fdata;
      rdata <= next_rdata;
      loader <= next_loader;
      idle_q <= next_idle_q;
      start <= next_start;
      rst_p <= next_rst_p;
      pcc <= next_pcc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign reg_rdata_out = rdata;
  assign cpu_reset_out = rst_p;
  assign pc_clear_out = pcc;
  assign fetch_loader_out = loader;
  assign flash_bank_out = cmd[`IFC_CMD_BANK];
  assign flash_output_enable_out = cmd[`IFC_CMD_OE];
  assign flash_chip_enable_out = cmd[`IFC_CMD_CE];
  assign flash_ctrl_out = cmd[`IFC_CMD_CTRL_HI:0];
  assign flash_addr_out = {addr_hi, addr_lo};
  assign flash_wdata_out = fdata;
  assign flash_start_out = start;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_key_pair;
    (wr_key && reg_wdata_in == `IFC_KEY_FIRST && !cpu_reset_out)
      ##1 (wr_key && reg_wdata_in == `IFC_KEY_SECOND && !cpu_reset_out);
  endsequence
  sequence s_wake_isp;
    wake && pcr[`IFC_PCR_ISP] && !loader && (pcr & `IFC_PCR_SWRESET) != `IFC_PCR_SWRESET;
  endsequence
  sequence s_wake_reset;
    wake && (pcr & `IFC_PCR_SWRESET) == `IFC_PCR_SWRESET;
  endsequence
  sequence s_op_capture;
    op_st == op_busy && flash_done_in && is_read;
  endsequence
  sequence s_cmd_write;
    reg_wr_in && reg_addr_in == `IFC_ADDR_CMD && !wake;
  endsequence

  a_key_open: assert property (s_key_pair |=> key_st == key_open)
    else $error("key pair did not open control register");
  a_key_close: assert property (wr_key && reg_wdata_in != `IFC_KEY_FIRST
    && reg_wdata_in != `IFC_KEY_SECOND |=> key_st == key_locked)
    else $error("stray key write left access open");
  a_pcr_locked: assert property (wr_pcr && key_st != key_open && !wake
    |=> pcr == $past(pcr))
    else $error("locked control register changed");
  a_op_in_idle: assert property (flash_start_out |-> core_idle_in && idle_q)
    else $error("flash operation started outside idle");
  a_op_start: assert property (op_st == op_run && enter && pcr[`IFC_PCR_ISP]
    |=> flash_start_out ##1 !flash_start_out)
    else $error("flash operation not started on idle entry");
  a_loader_switch: assert property (s_wake_isp
    |=> fetch_loader_out && pc_clear_out ##1 !pc_clear_out)
    else $error("no switch to loader bank on wake");
  a_soft_reset: assert property (s_wake_reset |=> cpu_reset_out && !fetch_loader_out
    ##1 !cpu_reset_out && pcr == `IFC_PCR_RESET)
    else $error("software reset not taken");
  a_read_data: assert property (s_op_capture
    |=> flash_wdata_out == $past(flash_rdata_in))
    else $error("flash read byte not captured");
  a_loader_flag: assert property (reg_rd_in && reg_addr_in == `IFC_ADDR_PCR
    |=> reg_rdata_out[`IFC_PCR_LOADER] == $past(loader))
    else $error("loader flag misread");
  a_main_fetch: assert property ($rose(fetch_loader_out) |-> $past(wake)
    && $past(pcr[`IFC_PCR_ISP]))
    else $error("loader fetch without programming mode");

  a_no_start_off: assert property (enter && !pcr[`IFC_PCR_ISP]
    |=> !flash_start_out)
    else $error("flash operation started without programming mode");
  a_start_pulse: assert property (flash_start_out
    |=> !flash_start_out)
    else $error("flash start longer than one cycle");
  a_pc_pulse: assert property (pc_clear_out
    |=> !pc_clear_out)
    else $error("program counter clear longer than one cycle");
  a_pc_loader: assert property (pc_clear_out
    |-> fetch_loader_out && !$past(fetch_loader_out))
    else $error("program counter clear without bank switch");
  a_rst_pulse: assert property (cpu_reset_out
    |=> !cpu_reset_out)
    else $error("software reset longer than one cycle");
  a_rst_locks: assert property (cpu_reset_out
    |=> key_st == key_locked)
    else $error("software reset left key open");
  a_mode_on_wake: assert property ($changed(fetch_loader_out) && $past(resetn_in)
    |-> $past(wake))
    else $error("fetch bank changed outside wake");
  a_cmd_ctrl: assert property (s_cmd_write
    |=> flash_ctrl_out == $past(reg_wdata_in[`IFC_CMD_CTRL_HI:0]))
    else $error("command control lines not driven");
  a_cmd_enables: assert property (s_cmd_write
    |=> flash_output_enable_out == $past(reg_wdata_in[`IFC_CMD_OE])
    && flash_chip_enable_out == $past(reg_wdata_in[`IFC_CMD_CE]))
    else $error("command enables not driven");
  a_cmd_bank: assert property (s_cmd_write
    |=> flash_bank_out == $past(reg_wdata_in[`IFC_CMD_BANK]))
    else $error("bank select not driven");
  a_addr_high: assert property (reg_wr_in && reg_addr_in == `IFC_ADDR_AHI
    |=> flash_addr_out == {$past(reg_wdata_in), $past(addr_lo)})
    else $error("address high byte not taken");
  a_addr_low: assert property (reg_wr_in && reg_addr_in == `IFC_ADDR_ALO
    |=> flash_addr_out == {$past(addr_hi), $past(reg_wdata_in)})
    else $error("address low byte not taken");
  a_data_write: assert property (reg_wr_in && reg_addr_in == `IFC_ADDR_FDATA
    && !(op_st == op_busy && flash_done_in && is_read)
    |=> flash_wdata_out == $past(reg_wdata_in))
    else $error("data register write lost");
endmodule : ifc_flash_ctrl

// file: ifc_flash_model.sv
// flash bank model facing the flash controller
`timescale 1ns/1ps
module ifc_flash_model #(parameter int DONE_DELAY = 4) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic bank_in,
  input wire logic oe_in,
  input wire logic ce_in,
  input wire logic [3:0] ctrl_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic start_in,
  output logic [7:0] rdata_out,
  output logic done_out
);
  logic [7:0] main_mem [int];
  logic [7:0] ldr_mem [int];
  int cnt = 0;
  int a;
  ////////////////////////////////////////////////////////////////
  // loader bank decodes 12 address bits
  assign a = bank_in ? int'(addr_in[11:0]) : int'(addr_in);
  initial begin
    rdata_out = 8'h00;
    done_out = 1'b0;
  end
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    rdata_out <= ~rdata_out; // idle data inverts every cycle
    if (!resetn_in) begin
      cnt <= 0;
    end else if (start_in && !ce_in) begin
      cnt <= DONE_DELAY;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        done_out <= 1'b1;
        case (ctrl_in)
          4'h2: if (oe_in) begin
            if (bank_in) ldr_mem.delete();
            else main_mem.delete();
          end
          4'h1: if (oe_in) begin
            if (bank_in) ldr_mem[a] = wdata_in;
            else main_mem[a] = wdata_in;
          end
          4'h0: if (!oe_in) begin
            if (bank_in) rdata_out <= ldr_mem.exists(a) ? ldr_mem[a] : 8'hff;
            else rdata_out <= main_mem.exists(a) ? main_mem[a] : 8'hff;
          end
          default: ;
        endcase
      end
    end
  end
endmodule : ifc_flash_model

// file: tb_isp_flash_controller.sv
// testbench of the flash controller
`timescale 1ns/1ps
`include "ifc_defs.svh"
module tb_isp_flash_controller;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, idle = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00;
  wire [7:0] rdata, frd, fwd;
  wire [15:0] fa;
  wire [3:0] fc;
  wire crst, pcc, fl, fb, foe, fce, fst, fdn;
  int num_errors = 0, check_count = 0, n_st = 0, n_pc = 0, n_rs = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////
  ifc_flash_ctrl i_dut (.sys_clk_in(clk), .resetn_in(rstn), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .core_idle_in(idle), .cpu_reset_out(crst), .pc_clear_out(pcc), .fetch_loader_out(fl),
    .flash_bank_out(fb), .flash_output_enable_out(foe), .flash_chip_enable_out(fce),
    .flash_ctrl_out(fc), .flash_addr_out(fa), .flash_wdata_out(fwd), .flash_start_out(fst),
    .flash_rdata_in(frd), .flash_done_in(fdn));
  ifc_flash_model i_flash (.clk_in(clk), .resetn_in(rstn), .bank_in(fb), .oe_in(foe),
    .ce_in(fce), .ctrl_in(fc), .addr_in(fa), .wdata_in(fwd), .start_in(fst),
    .rdata_out(frd), .done_out(fdn));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (fst === 1'b1) n_st++;
    if (pcc === 1'b1) n_pc++;
    if (crst === 1'b1) n_rs++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(16'(rdata), 16'(e), "read");
  endtask : rd_reg
  task automatic unlock();
    @(posedge clk);
    addr <= `IFC_ADDR_KEY;
    wd <= `IFC_KEY_FIRST;
    wr <= 1'b1;
    @(posedge clk);
    wd <= `IFC_KEY_SECOND;
    @(posedge clk);
    wr <= 1'b0;
  endtask : unlock
  task automatic idle_period(input int n);
    @(posedge clk);
    idle <= 1'b1;
    repeat (n) @(posedge clk);
    idle <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : idle_period
  ////////////////////////////////////////////////////////////////
  task automatic t_lock();
    rd_reg(`IFC_ADDR_CMD, 8'h30);
    rd_reg(8'h80, 8'h00);
    chk(16'(fl), 16'h0, "fetch main");
    wr_reg(`IFC_ADDR_PCR, 8'h01);
    rd_reg(`IFC_ADDR_PCR, 8'h00);
    idle_period(8);
    chk(16'(n_st), 16'h0, "no start");
    wr_reg(`IFC_ADDR_KEY, `IFC_KEY_SECOND);
    wr_reg(`IFC_ADDR_PCR, 8'h01);
    rd_reg(`IFC_ADDR_PCR, 8'h00);
    unlock();
    wr_reg(`IFC_ADDR_PCR, 8'h9b);
    rd_reg(`IFC_ADDR_PCR, 8'h9b);
    wr_reg(`IFC_ADDR_KEY, 8'h00);
    wr_reg(`IFC_ADDR_PCR, 8'h00);
    rd_reg(`IFC_ADDR_PCR, 8'h9b);
    unlock();
    wr_reg(`IFC_ADDR_PCR, 8'h01);
    wr_reg(`IFC_ADDR_KEY, 8'h00);
    $display("t_lock done");
  endtask : t_lock
  task automatic t_ops();
    logic [7:0] hi, lo, dt, cm;
    logic [3:0] op [3] = '{4'h2, 4'h1, 4'h0};
    int s;
    for (int b = 0; b < 2; b++) begin
      hi = b[0] ? 8'h01 : 8'h12;
      lo = b[0] ? 8'h23 : 8'h34;
      dt = b[0] ? 8'h5a : 8'ha5;
      wr_reg(`IFC_ADDR_AHI, hi);
      wr_reg(`IFC_ADDR_ALO, lo);
      for (int k = 0; k < 3; k++) begin
        cm = {1'b0, b[0], k != 2, 1'b0, op[k]};
        wr_reg(`IFC_ADDR_FDATA, (k == 2) ? 8'h00 : dt);
        wr_reg(`IFC_ADDR_CMD, cm);
        @(posedge clk);
        #1 chk({9'h0, fb, foe, fce, fc}, {9'h0, cm[6:0]}, "cmd");
        chk(fa, {hi, lo}, "addr");
        chk(16'(fwd), 16'((k == 2) ? 8'h00 : dt), "wdata");
        s = n_st;
        idle_period(10);
        chk(16'(n_st - s), 16'h1, "start");
      end
      rd_reg(`IFC_ADDR_FDATA, dt);
    end
    chk(16'(n_pc), 16'h1, "pc clear");
    chk(16'(fl), 16'h1, "loader");
    rd_reg(`IFC_ADDR_PCR, 8'h21);
    $display("t_ops done");
  endtask : t_ops
  task automatic t_swreset();
    unlock();
    wr_reg(`IFC_ADDR_PCR, `IFC_PCR_SWRESET);
    idle_period(10);
    chk(16'(n_rs), 16'h1, "sw reset");
    chk(16'(fl), 16'h0, "main");
    rd_reg(`IFC_ADDR_PCR, 8'h00);
    rd_reg(`IFC_ADDR_CMD, 8'h30);
    wr_reg(`IFC_ADDR_PCR, 8'h01);
    rd_reg(`IFC_ADDR_PCR, 8'h00);
    $display("t_swreset done");
  endtask : t_swreset
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_lock();
    t_ops();
    t_swreset();
    end_of_test();
  end
endmodule : tb_isp_flash_controller
